// File: bench/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
	input  wire logic  ref_clk,
	input  wire logic  txd,
	output logic       rxd,
	output logic [7:0] tx_byte
);
	logic [9:0] frm;
	initial rxd = 1'b1;
	initial tx_byte = 8'h00;
	// one frame, lsb first, 16 clocks a bit; nz flips one voted sample of bit 1
	task automatic send(input logic [9:0] f, input logic nz);
		for (int i = 0; i < 10; i++) begin
			for (int s = 0; s < 16; s++) begin
				@(posedge ref_clk);
				rxd <= f[i] ^ (nz && i == 1 && s == 8);
			end
		end
		@(posedge ref_clk);
		rxd <= 1'b1;
	endtask
	// samples the middle of each bit after a start edge
	initial forever begin
		@(negedge txd);
		repeat (8) @(posedge ref_clk);
		for (int i = 0; i < 10; i++) begin
			frm[i] = txd;
			// hand the byte over before the stop bit ends, ahead of tx_complete
			if (i == 8)
				tx_byte = frm[8:1];
			repeat (16) @(posedge ref_clk);
		end
	end
endmodule

// File: bench/serial_status_flags_test.sv
`timescale 1ns/1ps
`define check(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module serial_status_flags_test
	import serial_status_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst     = 1'b1;
	logic        cyc     = 1'b0;
	logic        stb     = 1'b0;
	logic        we      = 1'b0;
	logic [3:0]  adr     = 4'h0;
	logic [31:0] wdat    = 32'h0;
	logic [31:0] rd;
	wire  [31:0] dat_o;
	wire         ack;
	wire         rxd;
	wire         txd;
	wire  [7:0]  tx_byte;
	int          miscompares = 0;
	int          num_checks  = 0;
	always #12.5 ref_clk = ~ref_clk;
	serial_status_flags #(.ADR_W(4), .DIV_W(13)) uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.rxd(rxd), .txd(txd));
	serial_peer peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .tx_byte(tx_byte));
	// --------------------
	// bus tasks
	// --------------------
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) miscompares++;
	endtask
	task automatic wait_flag(input int b);
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_STATUS[3:0], 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 400);
	endtask
	// idle is masked: its timing depends on the gap between frames
	task automatic rx_case(input logic [9:0] f, input logic nz, input logic [7:0] st, input logic [7:0] dv);
		peer.send(f, nz);
		wait_flag(ST_RX_BUFFER_FULL);
		`check(rd[7:0] & 8'hEF, st)
		bus(1'b0, OFS_DATA[3:0], 32'h0);
		`check(rd[7:0], dv)
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0] & 8'hEF, 8'hC0)
	endtask
	task automatic results;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		miscompares++;
		results();
	end
	// --------------------
	// tests
	// --------------------
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], STATUS_RST)
		bus(1'b1, OFS_STATUS[3:0], 32'hFF);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], 8'hC0)
		bus(1'b1, OFS_CONTROL[3:0], 32'h10);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		bus(1'b1, OFS_DATA[3:0], 32'h5A);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], 8'h00)
		wait_flag(ST_TC);
		`check(rd[7:0], 8'hC0)
		`check(tx_byte, 8'h5A)
		bus(1'b1, OFS_CONTROL[3:0], 32'h30);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[ST_TC], 1'b0)
		bus(1'b1, OFS_CONTROL[3:0], 32'h00);
		wait_flag(ST_TC);
		peer.send({1'b1, 8'hA5, 1'b0}, 1'b0);
		wait_flag(ST_RX_BUFFER_FULL);
		`check(rd[7:0] & 8'hEF, 8'hE0)
		repeat (200) @(posedge ref_clk);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], 8'hF0)
		bus(1'b0, OFS_DATA[3:0], 32'h0);
		`check(rd[7:0], 8'hA5)
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], 8'hC0)
		repeat (200) @(posedge ref_clk);
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0], 8'hC0)
		peer.send({1'b1, 8'h11, 1'b0}, 1'b0);
		peer.send({1'b0, 8'h22, 1'b0}, 1'b0);
		wait_flag(ST_OR);
		`check(rd[7:0] & 8'hEF, 8'hE8)
		bus(1'b0, OFS_DATA[3:0], 32'h0);
		`check(rd[7:0], 8'h11)
		bus(1'b0, OFS_STATUS[3:0], 32'h0);
		`check(rd[7:0] & 8'hEF, 8'hC0)
		rx_case({1'b0, 8'h33, 1'b0}, 1'b0, 8'hE2, 8'h33);
		rx_case({1'b1, 8'h44, 1'b0}, 1'b1, 8'hE4, 8'h44);
		for (int m = 0; m < 2; m++) begin
			bus(1'b1, OFS_CONTROL[3:0], 32'h2 | m);
			rx_case({1'b1, 8'h01, 1'b0}, 1'b0, (m == 1) ? 8'hE0 : 8'hE1, 8'h01);
		end
		results();
	end
endmodule

// File: bench/status_checker.sv
`timescale 1ns/1ps
module status_checker
	import serial_status_pkg::*;
#(
	parameter int ADR_W = 4
) (
	input wire logic             ref_clk,
	input wire logic             rst,
	input wire logic             wb_cyc_i,
	input wire logic             wb_stb_i,
	input wire logic             wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0]      wb_dat_o,
	input wire logic             wb_ack_o,
	input wire logic             txd
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// --------------------
	// bus acknowledge and status read answer
	// --------------------
	sequence status_rd;
		wb_ack_o && $past(!wb_we_i && wb_adr_i[3:2] == 2'b00);
	endsequence
	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (!wb_ack_o && !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	status_width_a: assert property (status_rd |-> wb_dat_o[31:8] == 24'h0)
		else $error("status upper bits set");
	tc_needs_tx_buffer_empty_a: assert property (status_rd ##0 wb_dat_o[ST_TC] |-> wb_dat_o[ST_TX_BUFFER_EMPTY])
		else $error("complete while buffer full");
	tc_busy_low_a: assert property (status_rd ##0 !txd |-> !wb_dat_o[ST_TC])
		else $error("complete while line active");
	noise_with_full_a: assert property (status_rd ##0 wb_dat_o[ST_NF] |-> wb_dat_o[ST_RX_BUFFER_FULL])
		else $error("noise without full");
	frame_with_full_a: assert property (status_rd ##0 wb_dat_o[ST_FE] |-> wb_dat_o[ST_RX_BUFFER_FULL])
		else $error("framing without full");
	parity_with_full_a: assert property (status_rd ##0 wb_dat_o[ST_PF] |-> wb_dat_o[ST_RX_BUFFER_FULL])
		else $error("parity without full");
endmodule
bind serial_status_flags status_checker #(.ADR_W(ADR_W)) chk (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd(txd));

// File: hw/serial_status_flags.sv
`timescale 1ns/1ps
// What this block does
// - status register is read-only; writes to it change no flag
// - tx_buffer_empty is 1 after reset and set when shifter takes buffer
// - status read seeing tx_buffer_empty, then data write, clears it
// - tx_complete is 1 after reset and when idle; 0 while transmitting
// - armed tx_complete clears on data write, tx_on rise or break write
// - rx_buffer_full sets when a character enters the data register
// - status read seeing rx_buffer_full, then data read, clears it
// - idle sets after one character time (10 or 11 bits) of high line
// - idle count starts after start bit, or after stop bit if selected
// - status read seeing idle, then data read, clears idle
// - idle sets again only after a new character was received
// - overrun sets when new character meets unread one; new one dropped
// - status read seeing overrun, then data read, clears overrun
// - seven start samples, three per bit; disagreement sets noise_flag
// - noise_flag clears by status read then data read
// - framing_error sets with rx_buffer_full when stop bit samples 0
// - status read seeing framing_error, then data read, clears it
// - parity_error sets with rx_buffer_full on parity mismatch when on
// - parity_error clears by status read then data read
// - parity_odd_select 0 means even count of ones, 1 means odd
module serial_status_flags
	import serial_status_pkg::*;
#(
	parameter int ADR_W = 4,
	parameter int DIV_W = 13
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rxd,
	output logic             txd
);
	initial begin
		if (ADR_W < 4 || ADR_W > 8 || DIV_W < 1 || DIV_W > 16)
			$error("serial_status_flags: unsupported parameters");
	end

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_e;

	function automatic logic addr_is(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
		addr_is = (a[ADR_W-1:2] == ofs[ADR_W-1:2]);
	endfunction

	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	logic ack_q;
	logic acc;
	logic st_rd;
	logic dt_rd;
	logic dt_wr;
	logic ct_wr;
	logic bd_wr;
	logic [CT_W-1:0]  ctrl_q;
	logic [DIV_W-1:0] baud_q;
	logic [8:0]       rx_data_q;
	logic [8:0]       tx_buf_q;
	logic [7:0]       status_v;
	logic [7:0]       arm_q;

	assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wb_ack_o = ack_q;
	// status writes decode to nothing, so the flags cannot be touched
	assign st_rd = acc & ~wb_we_i & addr_is(wb_adr_i, OFS_STATUS);
	assign dt_rd = acc & ~wb_we_i & addr_is(wb_adr_i, OFS_DATA);
	assign dt_wr = acc & wb_we_i & wb_sel_i[0] & addr_is(wb_adr_i, OFS_DATA);
	assign ct_wr = acc & wb_we_i & wb_sel_i[0] & addr_is(wb_adr_i, OFS_CONTROL);
	assign bd_wr = acc & wb_we_i & wb_sel_i[0] & addr_is(wb_adr_i, OFS_BAUD);

	always_ff @(posedge ref_clk) begin
		if (rst)
			ack_q <= 1'b0;
		else
			ack_q <= acc;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (acc && !wb_we_i) begin
			if (addr_is(wb_adr_i, OFS_STATUS))
				wb_dat_o <= {24'h000000, status_v};
			else if (addr_is(wb_adr_i, OFS_DATA))
				wb_dat_o <= {23'h000000, rx_data_q};
			else if (addr_is(wb_adr_i, OFS_CONTROL))
				wb_dat_o <= {{(32-CT_W){1'b0}}, ctrl_q};
			else if (addr_is(wb_adr_i, OFS_BAUD))
				wb_dat_o <= {{(32-DIV_W){1'b0}}, baud_q};
			else
				wb_dat_o <= '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_RST[DIV_W-1:0];
		end else begin
			if (ct_wr)
				ctrl_q <= wb_dat_i[CT_W-1:0];
			if (bd_wr)
				baud_q <= wb_dat_i[DIV_W-1:0];
		end
	end

	// ----------------------------------------
	// 16x sample tick
	// ----------------------------------------
	logic [DIV_W-1:0] div_q;
	logic [DIV_W-1:0] baud_m1;
	logic             tick;

	// a divisor of zero behaves like one rather than stalling the link
	assign baud_m1 = (baud_q == '0) ? '0 : baud_q - 1'b1;
	assign tick    = (div_q >= baud_m1);

	always_ff @(posedge ref_clk) begin
		if (rst)
			div_q <= '0;
		else
			div_q <= tick ? '0 : div_q + 1'b1;
	end

	logic       long_c;
	logic [3:0] char_bits;
	logic [3:0] data_bits;
	assign long_c    = ctrl_q[CT_LONG];
	assign char_bits = long_c ? BITS_LONG : BITS_SHORT;
	assign data_bits = long_c ? DATA_LONG : DATA_SHORT;

	// ----------------------------------------
	// receiver
	// ----------------------------------------
	rx_state_e  rx_state_q;
	logic [3:0] rx_sub_q;
	logic [3:0] rx_idx_q;
	logic [8:0] rx_sh_q;
	logic [2:0] vote_q;
	logic       seen0_q;
	logic       seen1_q;
	logic       fnoise_q;
	logic [3:0] idle_bits_q;
	logic       bit_end;
	logic       bit_val;
	logic       bit_noise;
	logic       samp_en;
	logic       rx_done;
	logic [8:0] new_data;
	logic       new_pf;

	assign bit_end   = tick & (rx_sub_q == SUB_LAST);
	assign bit_val   = maj3(vote_q);
	assign bit_noise = seen0_q & seen1_q;
	assign samp_en   = (rx_sub_q <= SAMPLE_LAST) &&
		((rx_state_q == RX_START && rx_sub_q >= START_FIRST) ||
		 (rx_state_q == RX_BITS && rx_sub_q >= MID_FIRST));
	assign rx_done   = bit_end & (rx_state_q == RX_BITS) & (rx_idx_q == data_bits);
	assign new_data  = long_c ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
	// the parity bit is the top data bit, so the xor covers it too
	assign new_pf    = ctrl_q[CT_PAR] & ((^new_data) != ctrl_q[CT_ODD]);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q   <= '0;
			rx_idx_q   <= '0;
			rx_sh_q    <= '0;
			vote_q     <= '0;
			seen0_q    <= 1'b0;
			seen1_q    <= 1'b0;
			fnoise_q   <= 1'b0;
		end else if (tick) begin
			rx_sub_q <= rx_sub_q + 1'b1;
			if (samp_en) begin
				seen0_q <= seen0_q | ~rxd;
				seen1_q <= seen1_q | rxd;
				if (rx_sub_q >= MID_FIRST)
					vote_q <= {vote_q[1:0], rxd};
			end
			case (rx_state_q)
				RX_IDLE: begin
					if (!rxd) begin
						rx_state_q <= RX_START;
						rx_sub_q   <= '0;
						seen0_q    <= 1'b0;
						seen1_q    <= 1'b0;
					end
				end
				RX_START: begin
					if (rx_sub_q == SUB_LAST) begin
						seen0_q  <= 1'b0;
						seen1_q  <= 1'b0;
						fnoise_q <= bit_noise;
						rx_idx_q <= '0;
						// a start bit that votes high was a glitch
						rx_state_q <= bit_val ? RX_IDLE : RX_BITS;
					end
				end
				RX_BITS: begin
					if (rx_sub_q == SUB_LAST) begin
						seen0_q  <= 1'b0;
						seen1_q  <= 1'b0;
						fnoise_q <= fnoise_q | bit_noise;
						rx_idx_q <= rx_idx_q + 1'b1;
						if (rx_idx_q == data_bits)
							rx_state_q <= RX_IDLE;
						else
							rx_sh_q <= {bit_val, rx_sh_q[8:1]};
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// idle line counter
	// ----------------------------------------
	logic idle_armed_q;
	logic idle_set;

	assign idle_set = idle_armed_q & (rx_state_q == RX_IDLE) & (idle_bits_q >= char_bits);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			idle_bits_q <= '0;
		end else if (bit_end) begin
			if (rx_state_q == RX_START)
				idle_bits_q <= '0;
			else if (rx_state_q == RX_BITS && (ctrl_q[CT_ILT] || !bit_val))
				idle_bits_q <= '0;
			else if (rx_state_q == RX_IDLE && !rxd)
				idle_bits_q <= '0;
			else if (idle_bits_q != SUB_LAST)
				idle_bits_q <= idle_bits_q + 1'b1;
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	tx_state_e   tx_state_q;
	logic [3:0]  tx_sub_q;
	logic [3:0]  tx_idx_q;
	logic [10:0] tx_sh_q;
	logic        pre_q;
	logic        tx_buffer_empty_q;
	logic        tx_go;
	logic        load_pre;
	logic        load_brk;
	logic        load_data;
	logic        tx_end;
	logic        tx_par;
	logic [10:0] data_frame;
	logic        tx_on_new;
	logic        tx_rise;

	assign tx_on_new = ct_wr & wb_dat_i[CT_TXON];
	assign tx_rise   = tx_on_new & ~ctrl_q[CT_TXON];
	assign tx_go     = (tx_state_q == TX_IDLE) & ctrl_q[CT_TXON];
	assign load_pre  = tx_go & pre_q;
	assign load_brk  = tx_go & ~pre_q & ctrl_q[CT_BRK];
	assign load_data = tx_go & ~pre_q & ~ctrl_q[CT_BRK] & ~tx_buffer_empty_q;
	assign tx_end    = (tx_state_q == TX_SEND) & tick & (tx_sub_q == SUB_LAST) &
		(tx_idx_q == char_bits - 4'h1);
	assign tx_par    = (long_c ? ^tx_buf_q[7:0] : ^tx_buf_q[6:0]) ^ ctrl_q[CT_ODD];

	always_comb begin
		if (long_c)
			data_frame = {1'b1, ctrl_q[CT_PAR] ? tx_par : tx_buf_q[8], tx_buf_q[7:0], 1'b0};
		else
			data_frame = {2'b11, ctrl_q[CT_PAR] ? tx_par : tx_buf_q[7], tx_buf_q[6:0], 1'b0};
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			tx_buf_q <= '0;
		else if (dt_wr)
			tx_buf_q <= wb_dat_i[8:0];
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			pre_q <= 1'b0;
		else if (tx_rise)
			pre_q <= 1'b1;
		else if (load_pre)
			pre_q <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_state_q <= TX_IDLE;
			tx_sub_q   <= '0;
			tx_idx_q   <= '0;
			tx_sh_q    <= FRAME_ONES;
			txd        <= 1'b1;
		end else begin
			txd <= (tx_state_q == TX_SEND) ? tx_sh_q[0] : 1'b1;
			if (tx_go && (load_pre || load_brk || load_data)) begin
				tx_state_q <= TX_SEND;
				tx_sub_q   <= '0;
				tx_idx_q   <= '0;
				tx_sh_q    <= load_pre ? FRAME_ONES : (load_brk ? FRAME_ZERO : data_frame);
			end else if (tx_state_q == TX_SEND && tick) begin
				tx_sub_q <= tx_sub_q + 1'b1;
				if (tx_sub_q == SUB_LAST) begin
					tx_idx_q <= tx_idx_q + 1'b1;
					tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
					if (tx_end)
						tx_state_q <= TX_IDLE;
				end
			end
		end
	end

	// ----------------------------------------
	// status flags and clearing sequences
	// ----------------------------------------
	logic rx_buffer_full_q;
	logic tc_q;
	logic idle_q;
	logic or_q;
	logic nf_q;
	logic fe_q;
	logic pf_q;
	logic clr_rx_buffer_full;
	logic ovr_set;
	logic rx_load;
	logic tx_buffer_empty_d;
	logic tc_set;
	logic tc_clr;
	logic busy_d;
	logic brk_d;
	logic pre_d;

	assign status_v = {tx_buffer_empty_q, tc_q, rx_buffer_full_q, idle_q, or_q, nf_q, fe_q, pf_q};
	assign clr_rx_buffer_full = dt_rd & arm_q[ST_RX_BUFFER_FULL];
	assign ovr_set  = rx_done & rx_buffer_full_q & ~clr_rx_buffer_full;
	assign rx_load  = rx_done & ~ovr_set;

	assign tx_buffer_empty_d = load_data | (tx_buffer_empty_q & ~(dt_wr & arm_q[ST_TX_BUFFER_EMPTY]));
	assign brk_d  = ct_wr ? wb_dat_i[CT_BRK] : ctrl_q[CT_BRK];
	assign pre_d  = tx_rise | (pre_q & ~load_pre);
	assign busy_d = ((tx_state_q == TX_SEND) & ~tx_end) | load_pre | load_brk | load_data |
		pre_d | brk_d;
	assign tc_set = tx_buffer_empty_d & ~busy_d;
	assign tc_clr = arm_q[ST_TC] & (dt_wr | tx_rise | (ct_wr & wb_dat_i[CT_BRK]));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			tx_buffer_empty_q <= STATUS_RST[ST_TX_BUFFER_EMPTY];
			tc_q   <= STATUS_RST[ST_TC];
		end else begin
			tx_buffer_empty_q <= tx_buffer_empty_d;
			tc_q   <= tc_set | (tc_q & ~tc_clr & ~busy_d);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_buffer_full_q    <= STATUS_RST[ST_RX_BUFFER_FULL];
			or_q      <= STATUS_RST[ST_OR];
			nf_q      <= STATUS_RST[ST_NF];
			fe_q      <= STATUS_RST[ST_FE];
			pf_q      <= STATUS_RST[ST_PF];
			rx_data_q <= '0;
		end else begin
			if (rx_load)
				rx_data_q <= new_data;
			rx_buffer_full_q <= rx_load | (rx_buffer_full_q & ~clr_rx_buffer_full);
			or_q   <= ovr_set | (or_q & ~(dt_rd & arm_q[ST_OR]));
			nf_q   <= (rx_load & (fnoise_q | bit_noise)) | (nf_q & ~(dt_rd & arm_q[ST_NF]));
			fe_q   <= (rx_load & ~bit_val) | (fe_q & ~(dt_rd & arm_q[ST_FE]));
			pf_q   <= (rx_load & new_pf) | (pf_q & ~(dt_rd & arm_q[ST_PF]));
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			idle_q       <= STATUS_RST[ST_IDLE];
			idle_armed_q <= 1'b0;
		end else begin
			idle_q <= idle_set | (idle_q & ~(dt_rd & arm_q[ST_IDLE]));
			// only a freshly received character re-arms detection
			if (rx_load)
				idle_armed_q <= 1'b1;
			else if (idle_set)
				idle_armed_q <= 1'b0;
		end
	end

	// a status read records which flags it saw high; a data read then clears
	// the armed receive flags, and a data write the armed tx_buffer_empty and tx_complete
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arm_q <= '0;
		end else if (st_rd) begin
			arm_q <= status_v;
		end else begin
			if (dt_rd)
				arm_q[ST_RX_BUFFER_FULL:ST_PF] <= '0;
			if (dt_wr)
				arm_q[ST_TX_BUFFER_EMPTY] <= 1'b0;
			if (tc_clr)
				arm_q[ST_TC] <= 1'b0;
		end
	end
endmodule

// File: inc/serial_status_pkg.sv
package serial_status_pkg;
	// ----------------------------------------
	// register byte offsets (word aligned)
	// ----------------------------------------
	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_DATA    = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_BAUD    = 8'h0C;

	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int ST_TX_BUFFER_EMPTY = 7;
	localparam int ST_TC   = 6;
	localparam int ST_RX_BUFFER_FULL = 5;
	localparam int ST_IDLE = 4;
	localparam int ST_OR   = 3;
	localparam int ST_NF   = 2;
	localparam int ST_FE   = 1;
	localparam int ST_PF   = 0;

	// ----------------------------------------
	// control bit positions and reset values
	// ----------------------------------------
	localparam int CT_ODD   = 0;
	localparam int CT_PAR   = 1;
	localparam int CT_ILT   = 2;
	localparam int CT_LONG  = 3;
	localparam int CT_TXON  = 4;
	localparam int CT_BRK   = 5;
	localparam int CT_W     = 6;
	localparam logic [CT_W-1:0] CTRL_RST   = 6'h00;
	localparam logic [7:0]      STATUS_RST = 8'hC0;
	localparam logic [15:0]     BAUD_RST   = 16'h0001;

	// ----------------------------------------
	// bit timing in sample ticks
	// ----------------------------------------
	localparam logic [3:0] SUB_LAST    = 4'hF;
	localparam logic [3:0] START_FIRST = 4'h3;
	localparam logic [3:0] MID_FIRST   = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'h9;
	localparam logic [3:0] BITS_SHORT  = 4'hA;
	localparam logic [3:0] BITS_LONG   = 4'hB;
	localparam logic [3:0] DATA_SHORT  = 4'h8;
	localparam logic [3:0] DATA_LONG   = 4'h9;
	localparam logic [10:0] FRAME_ONES = 11'h7FF;
	localparam logic [10:0] FRAME_ZERO = 11'h000;
endpackage
